// ===== src/urfcm_pkg.sv
// constants and types shared by the receive frame qualification block
package urfcm_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] URFCM_ADR_SCTL   = 8'h00; // serial_control_reg
    localparam logic [7:0] URFCM_ADR_PCTL   = 8'h04; // power_control_reg
    localparam logic [7:0] URFCM_ADR_RBUF   = 8'h08; // serial_receive_buffer
    localparam logic [7:0] URFCM_ADR_IRQ_ST = 8'h0C; // event status, read only
    localparam logic [7:0] URFCM_ADR_IRQ_CL = 8'h10; // event clear, write only
    localparam logic [7:0] URFCM_ADR_IRQ_EN = 8'h14; // event enable

    // ------------------------------------------------------------
    // serial_control_reg bit positions
    // ------------------------------------------------------------
    localparam int URFCM_SC_UPPER = 7; // serial_mode_upper_bit or framing_error_flag
    localparam int URFCM_SC_LOWER = 6; // lower serial mode bit
    localparam int URFCM_SC_MPE   = 5; // multiproc_enable
    localparam int URFCM_SC_REN   = 4; // receive enable
    localparam int URFCM_SC_TB8   = 3; // transmit ninth bit storage
    localparam int URFCM_SC_RB8   = 2; // received_ninth_bit
    localparam int URFCM_SC_TI    = 1; // transmit flag storage
    localparam int URFCM_SC_RI    = 0; // receive_flag

    // ------------------------------------------------------------
    // power_control_reg bit positions
    // ------------------------------------------------------------
    localparam int URFCM_PC_DBL   = 7; // baud doubler storage
    localparam int URFCM_PC_FESEL = 6; // fe_access_select

    // ------------------------------------------------------------
    // event bits and reset values
    // ------------------------------------------------------------
    localparam int URFCM_EV_ACCEPT = 0; // frame loaded into buffer
    localparam int URFCM_EV_FERR   = 1; // stop bit missing
    localparam int URFCM_EV_DROP   = 2; // frame refused
    localparam int URFCM_EV_W      = 3;

    localparam logic [7:0]            URFCM_RST_BYTE = 8'h00;
    localparam logic [URFCM_EV_W-1:0] URFCM_RST_EV   = 3'h0;
    localparam logic [31:0]           URFCM_RD_ZERO  = 32'h0000_0000;

    // operating mode, in order of the two mode bits {upper, lower}
    typedef enum logic [1:0] {
        URFCM_MODE_SHIFT,
        URFCM_MODE_TEN,
        URFCM_MODE_ELEVEN_FIX,
        URFCM_MODE_ELEVEN_VAR
    } urfcm_mode_t;

endpackage // urfcm_pkg

// ===== src/urfcm_qualify.sv
// combinational accept and framing checks for one received frame
`timescale 1ns/10ps
module urfcm_qualify
    import urfcm_pkg::*;
(
    input  wire urfcm_mode_t mode_i,
    input  wire logic        multiproc_enable_i,
    input  wire logic        receive_flag_i,
    input  wire logic        ninth_i,
    input  wire logic        stop_i,
    output logic             accept_o,
    output logic             fe_set_o,
    output logic             ninth_store_o
);

    // ------------------------------------------------------------
    // per-mode decision
    // ------------------------------------------------------------
    always_comb
    begin
        accept_o      = 1'b0;
        fe_set_o      = 1'b0;
        ninth_store_o = ninth_i;
        case (mode_i)
            URFCM_MODE_SHIFT:
            begin
                // no framing check, enable bit ignored
                accept_o = !receive_flag_i;
            end
            URFCM_MODE_TEN:
            begin
                fe_set_o      = !stop_i;
                ninth_store_o = stop_i;     // stop bit takes the ninth place
                accept_o      = !receive_flag_i && (!multiproc_enable_i || stop_i);
            end
            URFCM_MODE_ELEVEN_FIX, URFCM_MODE_ELEVEN_VAR:
            begin
                fe_set_o = !stop_i;
                accept_o = !receive_flag_i && (!multiproc_enable_i || ninth_i);
            end
            default:
            begin
                accept_o = 1'b0;
            end
        endcase
    end

endmodule // urfcm_qualify

// ===== src/urfcm_irq.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/10ps
module urfcm_irq
    import urfcm_pkg::*;
#(
    parameter int EV_W = URFCM_EV_W
)
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic [EV_W-1:0] event_i,
    input  wire logic [EV_W-1:0] clear_i,
    input  wire logic            enable_we_i,
    input  wire logic [EV_W-1:0] enable_data_i,
    output logic      [EV_W-1:0] status_o,
    output logic      [EV_W-1:0] enable_o,
    output logic                 irq_o
);

    typedef struct packed {
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] enable;
        logic            irq;
    } urfcm_irq_t;

    urfcm_irq_t r;
    urfcm_irq_t next_r;

    // ------------------------------------------------------------
    // next state: a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    always_comb
    begin
        next_r        = r;
        next_r.status = (r.status & ~clear_i) | event_i;
        if (enable_we_i)
        begin
            next_r.enable = enable_data_i;
        end
        next_r.irq = |(next_r.status & next_r.enable);
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign status_o = r.status;
    assign enable_o = r.enable;
    assign irq_o    = r.irq;

endmodule // urfcm_irq

// ===== src/urfcm_top.sv
// receive frame qualification with framing error and multiprocessor filter
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps

module urfcm_top
    import urfcm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        frame_valid_i,
    input  wire logic [7:0]  frame_data_i,
    input  wire logic        frame_ninth_i,
    input  wire logic        frame_stop_i,
    output logic             irq_o,
    output logic             receive_flag_o,
    output logic [1:0]       serial_mode_o,
    output logic             receive_enable_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        serial_mode_upper_bit;
        logic        mode_lower;
        logic        multiproc_enable;
        logic        rx_enable;
        logic        tx_ninth;
        logic        received_ninth_bit;
        logic        tx_flag;
        logic        receive_flag;
        logic        framing_error_flag;
        logic        baud_double;
        logic        fe_access_select;
        logic [7:0]  rx_data;
        logic        ack;
        logic [31:0] rd_data;
    } urfcm_state_t;

    urfcm_state_t r;
    urfcm_state_t next_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        bus_req;
    logic        bus_wr;
    logic [7:0]  wr_byte;
    logic        hit_sctl;
    logic        hit_pctl;
    logic        hit_rbuf;
    logic        hit_st;
    logic        hit_cl;
    logic        hit_en;

    // take a request not yet answered; a write lands while ack stands
    assign bus_req  = wb_cyc_i && wb_stb_i && !r.ack;
    assign bus_wr   = wb_cyc_i && wb_stb_i && r.ack && wb_we_i && wb_sel_i[0];
    assign wr_byte  = wb_dat_i[7:0];
    assign hit_sctl = (wb_adr_i == URFCM_ADR_SCTL);
    assign hit_pctl = (wb_adr_i == URFCM_ADR_PCTL);
    assign hit_rbuf = (wb_adr_i == URFCM_ADR_RBUF);
    assign hit_st   = (wb_adr_i == URFCM_ADR_IRQ_ST);
    assign hit_cl   = (wb_adr_i == URFCM_ADR_IRQ_CL);
    assign hit_en   = (wb_adr_i == URFCM_ADR_IRQ_EN);

    // ------------------------------------------------------------
    // frame qualification
    // ------------------------------------------------------------
    urfcm_mode_t mode;
    logic        frame_seen;
    logic        q_accept;
    logic        q_fe_set;
    logic        q_ninth;

    assign mode       = urfcm_mode_t'({r.serial_mode_upper_bit, r.mode_lower});
    assign frame_seen = frame_valid_i && r.rx_enable;

    urfcm_qualify u_qualify (
        .mode_i             (mode),
        .multiproc_enable_i (r.multiproc_enable),
        .receive_flag_i     (r.receive_flag),
        .ninth_i            (frame_ninth_i),
        .stop_i             (frame_stop_i),
        .accept_o           (q_accept),
        .fe_set_o           (q_fe_set),
        .ninth_store_o      (q_ninth)
    );

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    logic [URFCM_EV_W-1:0] ev;
    logic [URFCM_EV_W-1:0] ev_clear;
    logic [URFCM_EV_W-1:0] ev_status;
    logic [URFCM_EV_W-1:0] ev_enable;
    logic                  ev_en_we;

    // one pulse per evaluated frame
    always_comb
    begin
        ev                  = URFCM_RST_EV;
        ev[URFCM_EV_ACCEPT] = frame_seen && q_accept;
        ev[URFCM_EV_FERR]   = frame_seen && q_fe_set;
        ev[URFCM_EV_DROP]   = frame_seen && !q_accept;
    end

    assign ev_clear = (bus_wr && hit_cl) ? wr_byte[URFCM_EV_W-1:0] : URFCM_RST_EV;
    assign ev_en_we = bus_wr && hit_en;

    urfcm_irq #(
        .EV_W (URFCM_EV_W)
    ) u_irq (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .event_i       (ev),
        .clear_i       (ev_clear),
        .enable_we_i   (ev_en_we),
        .enable_data_i (wr_byte[URFCM_EV_W-1:0]),
        .status_o      (ev_status),
        .enable_o      (ev_enable),
        .irq_o         (irq_o)
    );

    // ------------------------------------------------------------
    // register read views
    // ------------------------------------------------------------
    logic [7:0]  sctl_view;
    logic [7:0]  pctl_view;
    logic [31:0] rd_mux;

    // bit 7 shows one of two separate storage bits
    always_comb
    begin
        sctl_view                 = URFCM_RST_BYTE;
        sctl_view[URFCM_SC_UPPER] = r.fe_access_select ? r.framing_error_flag
                                                       : r.serial_mode_upper_bit;
        sctl_view[URFCM_SC_LOWER] = r.mode_lower;
        sctl_view[URFCM_SC_MPE]   = r.multiproc_enable;
        sctl_view[URFCM_SC_REN]   = r.rx_enable;
        sctl_view[URFCM_SC_TB8]   = r.tx_ninth;
        sctl_view[URFCM_SC_RB8]   = r.received_ninth_bit;
        sctl_view[URFCM_SC_TI]    = r.tx_flag;
        sctl_view[URFCM_SC_RI]    = r.receive_flag;
        pctl_view                 = URFCM_RST_BYTE;
        pctl_view[URFCM_PC_DBL]   = r.baud_double;
        pctl_view[URFCM_PC_FESEL] = r.fe_access_select;
    end

    // unmapped and write-only offsets read zero
    always_comb
    begin
        rd_mux = URFCM_RD_ZERO;
        if (hit_sctl)
        begin
            rd_mux[7:0] = sctl_view;
        end
        else if (hit_pctl)
        begin
            rd_mux[7:0] = pctl_view;
        end
        else if (hit_rbuf)
        begin
            rd_mux[7:0] = r.rx_data;
        end
        else if (hit_st)
        begin
            rd_mux[URFCM_EV_W-1:0] = ev_status;
        end
        else if (hit_en)
        begin
            rd_mux[URFCM_EV_W-1:0] = ev_enable;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r     = r;
        next_r.ack = 1'b0;

        // answer every request one cycle after it is taken
        if (bus_req)
        begin
            next_r.ack     = 1'b1;
            next_r.rd_data = wb_we_i ? r.rd_data : rd_mux;
        end

        // software writes to the control register
        if (bus_wr && hit_sctl)
        begin
            if (r.fe_access_select)
            begin
                // writing zero is the only way to clear the flag
                next_r.framing_error_flag = wr_byte[URFCM_SC_UPPER];
            end
            else
            begin
                next_r.serial_mode_upper_bit = wr_byte[URFCM_SC_UPPER];
            end
            next_r.mode_lower         = wr_byte[URFCM_SC_LOWER];
            next_r.multiproc_enable   = wr_byte[URFCM_SC_MPE];
            next_r.rx_enable          = wr_byte[URFCM_SC_REN];
            next_r.tx_ninth           = wr_byte[URFCM_SC_TB8];
            next_r.received_ninth_bit = wr_byte[URFCM_SC_RB8];
            next_r.tx_flag            = wr_byte[URFCM_SC_TI];
            next_r.receive_flag       = wr_byte[URFCM_SC_RI];
        end

        // software writes to the power control register
        if (bus_wr && hit_pctl)
        begin
            next_r.baud_double      = wr_byte[URFCM_PC_DBL];
            next_r.fe_access_select = wr_byte[URFCM_PC_FESEL];
        end

        // hardware updates come last so a set beats a clear
        if (frame_seen && q_fe_set)
        begin
            // set on every evaluated frame missing its stop bit outside shift mode, accepted or not
            next_r.framing_error_flag = 1'b1;
        end
        if (frame_seen && q_accept)
        begin
            // load buffer, ninth bit and flag together
            next_r.rx_data            = frame_data_i;
            next_r.received_ninth_bit = q_ninth;
            next_r.receive_flag       = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign wb_ack_o         = r.ack;
    assign wb_dat_o         = r.rd_data;
    assign receive_flag_o   = r.receive_flag;
    assign serial_mode_o    = {r.serial_mode_upper_bit, r.mode_lower};
    assign receive_enable_o = r.rx_enable;

endmodule // urfcm_top

// ===== tb/urfcm_checker.sv
// port assertions for the receive frame qualification block
`timescale 1ns/10ps
module urfcm_checker
    import urfcm_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        frame_valid_i,
    input wire logic [7:0]  frame_data_i,
    input wire logic        frame_ninth_i,
    input wire logic        frame_stop_i,
    input wire logic        irq_o,
    input wire logic        receive_flag_o,
    input wire logic [1:0]  serial_mode_o,
    input wire logic        receive_enable_o
);
    logic take;
    logic wr;
    logic wr_sc;
    logic wr_pc;
    logic wr_en;
    logic rx;
    logic mpe;
    logic fesel;
    // --------------------------------------------------------
    // request taken, control writes and frames evaluated
    // --------------------------------------------------------
    assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign wr    = wb_cyc_i && wb_stb_i && wb_ack_o && ce_i && wb_we_i && wb_sel_i[0];
    assign wr_sc = wr && wb_adr_i == URFCM_ADR_SCTL;
    assign wr_pc = wr && wb_adr_i == URFCM_ADR_PCTL;
    assign wr_en = wr && wb_adr_i == URFCM_ADR_IRQ_EN;
    assign rx    = frame_valid_i && receive_enable_o && ce_i;
    // shadow of filter enable and access select, which have no pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            {mpe, fesel} <= 2'b00;
        else if (wr_sc)
            mpe <= wb_dat_i[URFCM_SC_MPE];
        else if (wr_pc)
            fesel <= wb_dat_i[URFCM_PC_FESEL];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ack;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_pulse: assert property (take |-> s_ack)
        else $error("ack is not one pulse after a request");
    chk_frame_load: assert property (rx && !receive_flag_o && (!mpe || serial_mode_o == 2'b00) |=> receive_flag_o)
        else $error("qualified frame did not raise the receive flag");
    chk_mp_filter: assert property (rx && serial_mode_o[1] && mpe && !frame_ninth_i && !wr_sc |=> $stable(receive_flag_o))
        else $error("data frame passed the ninth bit filter");
    chk_ten_stop: assert property (rx && serial_mode_o == 2'b01 && mpe && !frame_stop_i && !wr_sc |=> $stable(receive_flag_o))
        else $error("frame without stop bit passed the filter");
    chk_flag_hold: assert property (receive_flag_o && !wr_sc |=> receive_flag_o)
        else $error("receive flag dropped without a write");
    chk_flag_cause: assert property ($rose(receive_flag_o) |-> $past(rx) || $past(wr_sc))
        else $error("receive flag rose without a frame");
    chk_mode_keep: assert property (wr_sc && fesel |=> $stable(serial_mode_o[1]))
        else $error("upper mode bit written while flag selected");
    chk_mode_cause: assert property (!$stable(serial_mode_o) |-> $past(wr_sc))
        else $error("mode changed without a control write");
    chk_irq_rise: assert property ($rose(irq_o) |-> $past(rx) || $past(wr_en) || $past(rx, 2) || $past(wr_en, 2))
        else $error("interrupt rose without event or enable");
endmodule // urfcm_checker

// ===== tb/urfcm_far_node.sv
// far serial node handing finished frames to the receive block
`timescale 1ns/10ps
module urfcm_far_node
(
    input  wire logic  clk_i,
    output logic       frame_valid_o,
    output logic [7:0] frame_data_o,
    output logic       frame_ninth_o,
    output logic       frame_stop_o
);
    // idle lines before the first frame
    initial {frame_valid_o, frame_data_o, frame_ninth_o, frame_stop_o} = 11'h001;
    // one frame after an idle gap; the lines are scrambled once it has gone
    task automatic send_frame(input logic [7:0] d, input logic n, input logic s, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        frame_valid_o <= 1'b1;
        frame_data_o  <= d;
        frame_ninth_o <= n;
        frame_stop_o  <= s;
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        frame_data_o  <= ~d;
        frame_ninth_o <= ~n;
        frame_stop_o  <= ~s;
    endtask
endmodule // urfcm_far_node

// ===== tb/tb_top.sv
// self-checking bench for the receive frame qualification block
`timescale 1ns/10ps
module tb_top
    import urfcm_pkg::*;
;
    logic        clk_i, rst_i, ce_i, cyc, stb, we, ack, fv, fn, fs, irq, rf, ren_o;
    logic [7:0]  adr, fd, rbuf;
    logic [3:0]  sel;
    logic [31:0] dw, dr, rd, r;
    logic [1:0]  mode_o, m;
    logic [2:0]  st, en;
    logic        mpe, ren, tb8, rb8, ti, ri, fe, fesel, dbl;
    int          errors, tests_run, cycles, seed;
    // system clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    urfcm_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .frame_valid_i(fv), .frame_data_i(fd), .frame_ninth_i(fn),
        .frame_stop_i(fs), .irq_o(irq), .receive_flag_o(rf), .serial_mode_o(mode_o),
        .receive_enable_o(ren_o)
    );
    urfcm_far_node i_far (
        .clk_i(clk_i), .frame_valid_o(fv), .frame_data_o(fd), .frame_ninth_o(fn),
        .frame_stop_o(fs)
    );
    // --------------------------------------------------------
    // bus tasks and the register model
    // --------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hF};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rd = dr;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(n, rd, exp);
    endtask
    function automatic logic [31:0] sc();
        return {24'h0, fesel ? fe : m[1], m[0], mpe, ren, tb8, rb8, ti, ri};
    endfunction
    function automatic logic [31:0] pc();
        return {24'h0, dbl, fesel, 6'h0};
    endfunction
    // read everything back, then the pins once settled
    task automatic check_all;
        rdc("sctl", URFCM_ADR_SCTL, sc());
        rdc("pctl", URFCM_ADR_PCTL, pc());
        rdc("rbuf", URFCM_ADR_RBUF, {24'h0, rbuf});
        rdc("status", URFCM_ADR_IRQ_ST, {29'h0, st});
        rdc("enable", URFCM_ADR_IRQ_EN, {29'h0, en});
        rdc("unmapped", 8'h18, 32'h0);
        chk("irq", 32'(irq), 32'(|(st & en)));
        chk("flag", 32'(rf), 32'(ri));
        chk("mode", 32'(mode_o), 32'(m));
        chk("rx_en", 32'(ren_o), 32'(ren));
    endtask
    // one frame from the far node, mirrored in the model
    task automatic frm(input logic [7:0] d, input logic n, input logic s);
        logic acc;
        logic ferr;
        i_far.send_frame(d, n, s, int'(r[31:30]));
        ferr = ren && m != 2'b00 && !s;
        acc  = ren && !ri && (!mpe || m == 2'b00 || (m == 2'b01 ? s : n));
        fe   = fe | ferr;
        if (acc)
        begin
            rbuf = d;
            rb8  = (m == 2'b01) ? s : n;
            ri   = 1'b1;
        end
        if (ren)
            st = st | {!acc, ferr, acc};
        @(posedge clk_i);
    endtask
    // hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            end_sim();
        end
    end
    // --------------------------------------------------------
    // reset, mode sweep in order with random settings, multiprocessor message
    // --------------------------------------------------------
    initial
    begin
        {ce_i, cyc, stb, we, adr, sel, dw, errors, tests_run, cycles} = '0;
        {m, mpe, ren, tb8, rb8, ti, ri, fe, fesel, dbl, rbuf, st, en, r} = '0;
        seed = 32'h9BCD8DBF;
        ce_i = 1'b1;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, URFCM_ADR_RBUF, 32'hFF);
        wb(1'b1, URFCM_ADR_IRQ_ST, 32'h7);
        check_all();
        for (int k = 0; k < 64; k++)
        begin
            r = $random(seed);
            m = 2'(k / 16);
            {mpe, tb8, ti, dbl} = r[3:0];
            ren = |r[5:4];
            ri = ri & r[6];
            en = r[9:7];
            fesel = 1'b0;
            wb(1'b1, URFCM_ADR_PCTL, pc());
            wb(1'b1, URFCM_ADR_SCTL, sc());
            wb(1'b1, URFCM_ADR_IRQ_EN, {29'h0, en});
            frm(r[23:16], m == 2'b00 ? rb8 : r[10], r[11]);
            if (r[12])
            begin
                wb(1'b1, URFCM_ADR_IRQ_CL, {29'h0, r[15:13]});
                st = st & ~r[15:13];
            end
            fesel = r[24];
            wb(1'b1, URFCM_ADR_PCTL, pc());
            if (fesel && r[25])
            begin
                fe = 1'b0;
                wb(1'b1, URFCM_ADR_SCTL, sc());
            end
            check_all();
        end
        fesel = 1'b0;
        wb(1'b1, URFCM_ADR_PCTL, pc());
        {m, mpe, ren, ri} = 5'b11110;
        wb(1'b1, URFCM_ADR_SCTL, sc());
        frm(8'h5A, 1'b0, 1'b1);
        frm(8'hA5, 1'b1, 1'b1);
        check_all();
        {mpe, ri} = 2'b00;
        wb(1'b1, URFCM_ADR_SCTL, sc());
        frm(8'h3C, 1'b0, 1'b1);
        check_all();
        {mpe, ri} = 2'b10;
        wb(1'b1, URFCM_ADR_SCTL, sc());
        frm(8'hC3, 1'b0, 1'b1);
        check_all();
        // an address frame while the clock enable is low leaves every register alone
        @(posedge clk_i);
        ce_i <= 1'b0;
        i_far.send_frame(8'h77, 1'b1, 1'b1, 0);
        ce_i <= 1'b1;
        check_all();
        end_sim();
    end
endmodule // tb_top
bind urfcm_top urfcm_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid_i(frame_valid_i),
    .frame_data_i(frame_data_i), .frame_ninth_i(frame_ninth_i),
    .frame_stop_i(frame_stop_i), .irq_o(irq_o), .receive_flag_o(receive_flag_o),
    .serial_mode_o(serial_mode_o), .receive_enable_o(receive_enable_o)
);
